// ---- hw/chfr_pkg.sv ----
package chfr_pkg;
  // ==========================================================
  // Fault sources
  localparam int NUM_FAULTS = 5;
  localparam int FLT_OT = 0;
  localparam int FLT_UT = 1;
  localparam int FLT_VIN_OV = 2;
  localparam int FLT_VIN_UV = 3;
  localparam int FLT_TON_MAX = 4;
  // ==========================================================
  // Fault reaction byte layout
  localparam int ACT_MSB = 7;
  localparam int ACT_LSB = 6;
  localparam int RTY_MSB = 5;
  localparam int RTY_LSB = 3;
  localparam logic [2:0] DLY_FIXED = 3'h0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic OP_ON_RST = 1'b1;
  // ==========================================================
  // Status bit positions
  localparam int SB_OFF = 6;
  localparam int SB_VIN_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_HIGH = 0;
  localparam int SW_VOUT = 15;
  localparam int SW_INPUT = 13;
  localparam int SV_TON_MAX = 2;
  localparam int ST_OT = 7;
  localparam int ST_UT = 4;
  localparam int SI_OV = 7;
  localparam int SI_UV = 4;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 25;
  localparam int RETRY_WAIT_US = 100;
  localparam int RETRY_WAIT_CYC = RETRY_WAIT_US * CLK_MHZ;
  localparam logic [11:0] RETRY_LAST = 12'(RETRY_WAIT_CYC - 1);
  // ==========================================================
  // Channel states
  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_SEQ_OFF, ST_FAULT_OFF, ST_RETRY_WAIT
  } chfr_state_e;
endpackage

// ---- hw/chfr_ctrl.sv ----
`timescale 1ns/1ns
// Behaviour
// RQ1: ADC fault with zero action leaves the channel running undisturbed.
// RQ2: ADC fault with nonzero action shuts down or sequences off, then retry applies.
// RQ3: Zero retry field means no restart; output stays off until cleared.
// RQ4: Nonzero retry restarts up to global count; off command or fault stops it.
// RQ5: Delay field of every reaction byte reads zero; no deglitch added.
// RQ6: Start-up timeout: zero action keeps running, else shut down then retry.
// RQ7: Start-up timeout sets high-byte, vout word and timeout status bits.
// RQ8: Start-up timeout pulls the active-low alert output low.
// RQ9: Host uses timeout reaction at start-up, undervolt reaction afterwards.
// RQ10: ADC faults set summary and detail status bits and assert alert.
// RQ11: Fault shutdown latches off until pin toggle, on/off command or bias loss.
// RQ12: Per-channel attempt counter, cleared on latch release, caps restarts.
module chfr_ctrl
  import chfr_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [chfr_pkg::NUM_FAULTS-1:0] fault_event,
  input wire logic channel_control_pin,
  input wire logic on_cmd,
  input wire logic off_cmd,
  input wire logic clear_faults,
  input wire logic immediate_off,
  input wire logic toff_done,
  input wire logic [2:0] retry_count,
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_sel,
  input wire logic [7:0] cfg_wdata,
  input wire logic [2:0] cfg_rsel,
  output logic [7:0] cfg_rdata,
  output logic channel_enable,
  output logic alert_output_n,
  output logic [15:0] status_word,
  output logic [7:0] status_vout,
  output logic [7:0] status_input,
  output logic [7:0] status_temperature,
  output logic [2:0] retry_attempts
);
  import chfr_pkg::*;

  // ==========================================================
  // Control pin synchroniser
  logic ctrl_meta;
  logic ctrl_sync;
  logic ctrl_prev;
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      ctrl_meta <= 1'b0;
      ctrl_sync <= 1'b0;
      ctrl_prev <= 1'b0;
    end
    else
    begin
      ctrl_meta <= channel_control_pin;
      ctrl_sync <= ctrl_meta;
      ctrl_prev <= ctrl_sync;
    end
  end

  // ==========================================================
  // Fault reaction bytes
  logic [7:0] cfg [NUM_FAULTS];
  logic [NUM_FAULTS-1:0] shut_hit;
  logic [NUM_FAULTS-1:0] nort_hit;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FAULTS; gi++)
    begin : g_fault
      logic [7:0] next_cfg;
      always_comb
      begin
        next_cfg = cfg[gi];
        if (cfg_wr && cfg_sel == 3'(gi))
          next_cfg = {cfg_wdata[7:3], DLY_FIXED}; // [RQ5]
      end
      always_ff @(posedge clock)
      begin
        if (!nrst)
          cfg[gi] <= CFG_RST;
        else
          cfg[gi] <= next_cfg;
      end
      // Zero action keeps running, nonzero shuts down
      assign shut_hit[gi] = fault_event[gi] && (cfg[gi][ACT_MSB:ACT_LSB] != 2'h0); // [RQ1] [RQ6]
      assign nort_hit[gi] = shut_hit[gi] && (cfg[gi][RTY_MSB:RTY_LSB] == 3'h0); // [RQ3]
    end
  endgenerate

  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    if (cfg_rsel < 3'(NUM_FAULTS))
      next_rdata = cfg[cfg_rsel];
  end
  always_ff @(posedge clock)
  begin
    if (!nrst)
      cfg_rdata <= 8'h00;
    else
      cfg_rdata <= next_rdata;
  end

  // ==========================================================
  // Channel state
  chfr_state_e state;
  chfr_state_e next_state;
  logic op_on;
  logic next_op_on;
  logic retry_ok;
  logic next_retry_ok;
  logic [2:0] next_attempts;
  logic [11:0] wait_cnt;
  logic [11:0] next_wait_cnt;
  logic next_enable;
  logic latch_clr;
  logic on_req;
  logic fault_shut;

  assign latch_clr = (ctrl_sync ^ ctrl_prev) | on_cmd | off_cmd; // [RQ11]
  assign on_req = ctrl_sync & op_on;
  assign fault_shut = |shut_hit;

  always_comb
  begin
    next_state = state;
    next_retry_ok = retry_ok;
    next_attempts = retry_attempts;
    next_wait_cnt = wait_cnt;
    next_op_on = op_on;
    if (on_cmd)
      next_op_on = 1'b1;
    else if (off_cmd)
      next_op_on = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        next_attempts = 3'h0; // [RQ12]
        if (on_req && !latch_clr)
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (fault_shut)
        begin
          next_retry_ok = ~|nort_hit; // [RQ3]
          next_state = immediate_off ? ST_FAULT_OFF : ST_SEQ_OFF; // [RQ2] [RQ6]
        end
        else if (!on_req)
          next_state = ST_IDLE;
      end
      ST_SEQ_OFF:
      begin
        // Turn-off delay is timed outside; only its end is seen here
        if (|nort_hit)
          next_retry_ok = 1'b0;
        if (toff_done)
          next_state = ST_FAULT_OFF; // [RQ2]
      end
      ST_FAULT_OFF:
      begin
        if (latch_clr)
        begin
          next_state = ST_IDLE; // [RQ11]
          next_attempts = 3'h0; // [RQ12]
        end
        else if (retry_ok && retry_attempts < retry_count)
        begin
          next_state = ST_RETRY_WAIT; // [RQ4] [RQ12]
          next_wait_cnt = 12'h000;
        end
      end
      ST_RETRY_WAIT:
      begin
        if (latch_clr || !on_req)
        begin
          next_state = ST_IDLE; // [RQ4]
          next_attempts = 3'h0; // [RQ12]
        end
        else if (fault_shut)
        begin
          next_retry_ok = 1'b0; // [RQ4]
          next_state = ST_FAULT_OFF;
        end
        else if (wait_cnt == RETRY_LAST)
        begin
          next_state = ST_RUN;
          next_attempts = retry_attempts + 3'h1; // [RQ12]
        end
        else
          next_wait_cnt = wait_cnt + 12'h001;
      end
    endcase
    next_enable = (next_state == ST_RUN) || (next_state == ST_SEQ_OFF);
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      op_on <= OP_ON_RST;
      retry_ok <= 1'b0;
      retry_attempts <= 3'h0;
      wait_cnt <= 12'h000;
      channel_enable <= 1'b0;
    end
    else
    begin
      state <= next_state;
      op_on <= next_op_on;
      retry_ok <= next_retry_ok;
      retry_attempts <= next_attempts;
      wait_cnt <= next_wait_cnt;
      channel_enable <= next_enable;
    end
  end

  // ==========================================================
  // Status and alert
  // Sets are applied after the clear so a same-cycle event survives
  logic [15:0] next_word;
  logic [7:0] next_vout;
  logic [7:0] next_input;
  logic [7:0] next_temp;
  logic alert;
  logic next_alert;
  always_comb
  begin
    next_word = clear_faults ? 16'h0000 : status_word;
    next_vout = clear_faults ? 8'h00 : status_vout;
    next_input = clear_faults ? 8'h00 : status_input;
    next_temp = clear_faults ? 8'h00 : status_temperature;
    next_alert = (alert && !clear_faults) || (|fault_event); // [RQ8] [RQ10]
    if (fault_event[FLT_OT])
    begin
      next_temp[ST_OT] = 1'b1; // [RQ10]
      next_word[SB_TEMP] = 1'b1;
    end
    if (fault_event[FLT_UT])
    begin
      next_temp[ST_UT] = 1'b1; // [RQ10]
      next_word[SB_TEMP] = 1'b1;
    end
    if (fault_event[FLT_VIN_OV])
    begin
      next_input[SI_OV] = 1'b1; // [RQ10]
      next_word[SW_INPUT] = 1'b1;
      next_word[SB_HIGH] = 1'b1;
    end
    if (fault_event[FLT_VIN_UV])
    begin
      next_input[SI_UV] = 1'b1; // [RQ10]
      next_word[SW_INPUT] = 1'b1;
      next_word[SB_VIN_UV] = 1'b1;
    end
    if (fault_event[FLT_TON_MAX])
    begin
      next_vout[SV_TON_MAX] = 1'b1; // [RQ7]
      next_word[SW_VOUT] = 1'b1;
      next_word[SB_HIGH] = 1'b1;
    end
    // Off bit is live, not sticky
    next_word[SB_OFF] = !next_enable;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      status_word <= 16'h0040;
      status_vout <= 8'h00;
      status_input <= 8'h00;
      status_temperature <= 8'h00;
      alert <= 1'b0;
    end
    else
    begin
      status_word <= next_word;
      status_vout <= next_vout;
      status_input <= next_input;
      status_temperature <= next_temp;
      alert <= next_alert;
    end
  end
  assign alert_output_n = !alert; // [RQ8]

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_run_fault;
    state == ST_RUN && fault_shut;
  endsequence
  sequence s_retry_end;
    state == ST_RETRY_WAIT && wait_cnt == RETRY_LAST && !latch_clr && on_req && !fault_shut;
  endsequence

  a_keep_running: assert property (state == ST_RUN && !fault_shut && on_req |=> state == ST_RUN) // [RQ1]
    else $error("channel left run without shutdown fault");
  a_immediate_off: assert property (s_run_fault and immediate_off |=> state == ST_FAULT_OFF && !channel_enable) // [RQ2]
    else $error("immediate shutdown missed");
  a_seq_off: assert property (s_run_fault and !immediate_off |=> state == ST_SEQ_OFF && channel_enable) // [RQ6]
    else $error("sequenced shutdown missed");
  a_no_restart: assert property (state == ST_FAULT_OFF && !retry_ok |=> state != ST_RETRY_WAIT) // [RQ3]
    else $error("restart with zero retry field");
  a_retry_step: assert property (s_retry_end |=> state == ST_RUN && retry_attempts == $past(retry_attempts) + 3'h1) // [RQ4]
    else $error("retry restart wrong");
  a_retry_cap: assert property (state == ST_RETRY_WAIT |-> retry_attempts < retry_count) // [RQ12]
    else $error("retry beyond global count");
  a_delay_zero: assert property (cfg_wr ##1 cfg_rsel == $past(cfg_sel) |=> cfg_rdata[2:0] == 3'h0) // [RQ5]
    else $error("delay field not zero");
  a_ton_status: assert property (fault_event[FLT_TON_MAX] |=> status_word[SW_VOUT] && status_word[SB_HIGH] && status_vout[SV_TON_MAX]) // [RQ7]
    else $error("timeout status bits not set");
  a_alert_low: assert property (|fault_event |=> !alert_output_n) // [RQ8]
    else $error("alert not asserted");
  a_adc_status: assert property (fault_event[FLT_OT] |=> status_temperature[ST_OT] && status_word[SB_TEMP]) // [RQ10]
    else $error("overtemp status not set");
  a_latch_hold: assert property (state == ST_FAULT_OFF && !latch_clr |=> state inside {ST_FAULT_OFF, ST_RETRY_WAIT}) // [RQ11]
    else $error("fault latch released without clear");
endmodule // chfr_ctrl

// ---- verif/chfr_toff_model.sv ----
`timescale 1ns/1ns
// ==========================================================
// Far side turn-off timer; stands idle until started
module chfr_toff_model
(
  input wire logic clock,
  input wire logic start,
  input wire logic [7:0] dly,
  output logic toff_done
);
  int cnt = 0;
  initial toff_done = 1'b0;
  always @(posedge clock)
  begin
    toff_done <= (cnt == 1);
    if (start)
      cnt <= int'(dly) + 1;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule // chfr_toff_model

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
  import chfr_pkg::*;
  logic clock = 0, nrst = 0, channel_control_pin = 0, on_cmd = 0, off_cmd = 0;
  logic clear_faults = 0, immediate_off = 0, cfg_wr = 0, toff_start = 0;
  logic [4:0] fault_event = 5'h0;
  logic [2:0] retry_count = 3'h0, cfg_sel = 3'h0, cfg_rsel = 3'h0, retry_attempts;
  logic [7:0] cfg_wdata = 8'h0, toff_dly = 8'h4, cfg_rdata, status_vout, status_input;
  logic [7:0] status_temperature;
  logic [15:0] status_word;
  logic channel_enable, alert_output_n, toff_done;
  int n_errors = 0, total_checks = 0, n, f, rc;
  int m_cfg [8] = '{8{0}};
  int m_det [3] = '{3{0}};
  int m_word = 0;
  bit exp_en = 0;
  int w_bits [5] = '{1 << SB_TEMP, 1 << SB_TEMP, (1 << SW_INPUT) | (1 << SB_HIGH),
    (1 << SW_INPUT) | (1 << SB_VIN_UV), (1 << SW_VOUT) | (1 << SB_HIGH)};
  int d_bits [5] = '{1 << ST_OT, 1 << ST_UT, 1 << SI_OV, 1 << SI_UV, 1 << SV_TON_MAX};
  chfr_ctrl dut (.clock, .nrst, .fault_event, .channel_control_pin, .on_cmd, .off_cmd,
    .clear_faults, .immediate_off, .toff_done, .retry_count, .cfg_wr, .cfg_sel, .cfg_wdata,
    .cfg_rsel, .cfg_rdata, .channel_enable, .alert_output_n, .status_word, .status_vout,
    .status_input, .status_temperature, .retry_attempts);
  chfr_toff_model partner (.clock, .start(toff_start), .dly(toff_dly), .toff_done);
  initial forever #20 clock = ~clock;
  // ==========================================================
  // Shared tasks
  task tick;
    @(posedge clock);
    #1;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_st;
    chk("enable", 16'(exp_en), 16'(channel_enable));
    chk("alert_n", 16'(m_word == 0), 16'(alert_output_n));
    chk("word", 16'(m_word) | (exp_en ? 16'h0 : 16'h0040), status_word);
    chk("temp", 16'(m_det[0]), 16'(status_temperature));
    chk("input", 16'(m_det[1]), 16'(status_input));
    chk("vout", 16'(m_det[2]), 16'(status_vout));
  endtask
  task fault(input int k, input bit seq);
    fault_event = 5'(1 << k);
    toff_start = seq;
    tick;
    fault_event = 5'h0;
    toff_start = 0;
    m_word |= w_bits[k];
    m_det[k < 2 ? 0 : (k < 4 ? 1 : 2)] |= d_bits[k];
  endtask
  task pulse_clear;
    clear_faults = 1;
    tick;
    clear_faults = 0;
    m_word = 0;
    m_det = '{3{0}};
  endtask
  task wcfg(input int s, input logic [7:0] v);
    cfg_wr = 1;
    cfg_sel = 3'(s);
    cfg_wdata = v;
    tick;
    cfg_wr = 0;
    if (s < 5)
      m_cfg[s] = int'(v & 8'hf8);
  endtask
  task rcfg(input int s);
    cfg_rsel = 3'(s);
    tick;
    chk("cfg", 16'(m_cfg[s]), 16'(cfg_rdata));
  endtask
  task wait_en(input bit v);
    n = 0;
    while (channel_enable !== v && n < 3000)
    begin
      tick;
      n++;
    end
  endtask
  task cmd(input bit on);
    on_cmd = on;
    off_cmd = !on;
    tick;
    on_cmd = 0;
    off_cmd = 0;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Watchdog, well beyond the expected 17k cycles at most
  initial
  begin
    #(40 * 60000);
    n_errors++;
    complete_run;
  end
  // ==========================================================
  // Tests
  initial
  begin
    void'($urandom(32'h16e06dcb));
    repeat (12) tick;
    nrst = 1;
    chk_st;
    for (int s = 0; s < 8; s++) rcfg(s);
    for (int s = 0; s < 6; s++)
    begin
      wcfg(s, 8'($urandom));
      rcfg(s);
    end
    channel_control_pin = 1;
    wait_en(1);
    exp_en = 1;
    chk("on_delay", 16'h4, 16'(n));
    $display("test reset_and_config done");
    // Zero action; every fault, timeout included, injected while running
    for (int k = 0; k < 5; k++)
    begin
      wcfg(k, 8'(($urandom % 8) << RTY_LSB));
      fault(k, 0);
      chk_st;
      pulse_clear;
      chk_st;
    end
    $display("test keep_running done");
    immediate_off = 1;
    wcfg(FLT_TON_MAX, 8'((1 + $urandom % 3) << ACT_LSB));
    fault(FLT_TON_MAX, 0);
    exp_en = 0;
    chk_st;
    pulse_clear;
    chk_st;
    wait_en(1);
    chk("latched", 16'd3000, 16'(n));
    channel_control_pin = 0;
    repeat (3) tick;
    channel_control_pin = 1;
    wait_en(1);
    exp_en = 1;
    chk("pin_release", 16'h1, 16'(channel_enable));
    chk("attempts", 16'h0, 16'(retry_attempts));
    $display("test latch_off done");
    // Sequenced off with a bounded number of restarts
    rc = 1 + $urandom % 3;
    retry_count = 3'(rc);
    immediate_off = 0;
    f = $urandom % 4;
    toff_dly = 8'(1 + $urandom % 20);
    wcfg(f, 8'(((1 + $urandom % 3) << ACT_LSB) | ((1 + $urandom % 7) << RTY_LSB)));
    for (int k = 1; k <= rc + 1; k++)
    begin
      fault(f, 1);
      chk("seq_off", 16'h1, 16'(channel_enable));
      wait_en(0);
      chk("toff", 16'h0, 16'(channel_enable));
      wait_en(1);
      if (k <= rc)
      begin
        chk("retry_wait", 16'(RETRY_WAIT_CYC + 1), 16'(n));
        chk("attempts", 16'(k), 16'(retry_attempts));
      end
      else
        chk("no_retry", 16'd3000, 16'(n));
    end
    exp_en = 0;
    chk_st;
    cmd(0);
    chk("attempts", 16'h0, 16'(retry_attempts));
    cmd(1);
    wait_en(1);
    chk("on_cmd", 16'h1, 16'(channel_enable));
    fault(f, 1);
    wait_en(0);
    tick;
    cmd(0);
    wait_en(1);
    chk("off_stops", 16'd3000, 16'(n));
    $display("test retry done");
    complete_run;
  end
endmodule // tb
